/* core/gpio_ports.sv */
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`include "gpio_params.svh"

module gpio_ports
    import gpio_pkg::*;
#(
    parameter logic [15:0] PORT_A_PINS = `GPIO_A_PIN_MASK,
    parameter logic [15:0] PORT_B_PINS = `GPIO_B_PIN_MASK
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] port_soft_reset,
    input wire logic [1:0][15:0] pad_in,
    output logic [1:0][15:0] pad_output_enable_n,
    output logic [1:0][15:0] pad_input_enable_n,
    output logic [1:0][15:0] pad_data_out,
    output logic [1:0][15:0] pad_opendrain,
    output logic [1:0][15:0] pad_pullup,
    output logic [1:0][15:0] pad_pulldown,
    output logic [1:0][31:0] pad_drive,
    output logic [1:0][15:0] altfunc_lock
);

    state_t state;
    state_t next_state;

    function automatic logic [15:0] pin_mask(input logic idx);
        pin_mask = idx ? PORT_B_PINS : PORT_A_PINS;
    endfunction

    function automatic logic [31:0] widen2(input logic [15:0] bits);
        logic [31:0] w;
        w = '0;
        for (int k = 0; k < 16; k++)
        begin
            w[2*k +: 2] = {2{bits[k]}};
        end
        widen2 = w;
    endfunction

    // Pad controls follow the register contents of the same cycle
    function automatic port_t pads(input port_t p);
        port_t q;
        q = p;
        q.oe_n = ~p.dir;
        q.ie_n = ~p.inen;
        q.pull_up = p.pu;
        q.pull_dn = p.pd & ~p.pu;
        pads = q;
    endfunction

    function automatic port_t port_rst(input logic idx);
        port_t p;
        p = '0;
        if (!idx)
        begin
            p.inen = `GPIO_A_INEN_RST;
            p.pu = `GPIO_A_PU_RST;
            p.din = `GPIO_A_DIN_RST;
        end
        else
        begin
            p.inen = `GPIO_B_CFG_RST;
            p.pu = `GPIO_B_CFG_RST;
        end
        port_rst = pads(p);
    endfunction

    function automatic state_t state_rst();
        state_t s;
        s = '0;
        s.port[0] = port_rst(1'b0);
        s.port[1] = port_rst(1'b1);
        state_rst = s;
    endfunction

    localparam state_t RST_STATE = state_rst();

    // Locked bits keep their old value, reserved bits stay zero
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [15:0] lk, input logic [15:0] msk);
        merge16 = (old & lk) | (wd & ~lk & msk);
    endfunction

    function automatic logic offset_known(input logic [11:0] off);
        offset_known = (off[1:0] == 2'h0) && (off <= `GPIO_OFF_RR);
    endfunction

    function automatic port_t write_reg(input port_t p, input logic [11:0] off,
                                       input logic [31:0] wd, input logic [15:0] msk);
        port_t q;
        q = p;
        case (off)
            `GPIO_OFF_DIR: q.dir = merge16(p.dir, wd[15:0], p.lock, msk);
            `GPIO_OFF_INEN: q.inen = merge16(p.inen, wd[15:0], p.lock, msk);
            `GPIO_OFF_PU: q.pu = merge16(p.pu, wd[15:0], p.lock, msk);
            `GPIO_OFF_PD: q.pd = merge16(p.pd, wd[15:0], p.lock, msk);
            `GPIO_OFF_OD: q.od = merge16(p.od, wd[15:0], p.lock, msk);
            `GPIO_OFF_DRV: q.drv = (p.drv & widen2(p.lock))
                | (wd & ~widen2(p.lock) & widen2(msk));
            `GPIO_OFF_LOCK:
            begin
                if (!p.locked && wd[`GPIO_KEY_MSB:`GPIO_KEY_LSB] == `GPIO_LOCK_KEY)
                begin
                    q.locked = 1'b1;
                    q.lock = wd[15:0] & msk;
                end
            end
            `GPIO_OFF_DOUT: q.dout = wd[15:0] & msk;
            `GPIO_OFF_SRR: q.dout = ((p.dout & ~wd[31:16]) | wd[15:0]) & msk;
            `GPIO_OFF_RR: q.dout = p.dout & ~wd[15:0];
            default: q = p;
        endcase
        write_reg = q;
    endfunction

    function automatic logic [31:0] read_reg(input port_t p, input logic [11:0] off);
        logic [31:0] r;
        r = '0;
        case (off)
            `GPIO_OFF_DIR: r[15:0] = p.dir;
            `GPIO_OFF_INEN: r[15:0] = p.inen;
            `GPIO_OFF_PU: r[15:0] = p.pu;
            `GPIO_OFF_PD: r[15:0] = p.pd;
            `GPIO_OFF_OD: r[15:0] = p.od;
            `GPIO_OFF_DRV: r = p.drv;
            `GPIO_OFF_LOCK: r = {(p.locked ? `GPIO_LOCK_KEY : 16'h0000), p.lock};
            `GPIO_OFF_DIN: r[15:0] = p.din;
            `GPIO_OFF_DOUT: r[15:0] = p.dout;
            default: r = '0;
        endcase
        read_reg = r;
    endfunction

    logic hit;
    logic sel_port;
    logic setup;
    logic wr_go;
    logic [11:0] off;

    always_comb
    begin
        next_state = state;
        off = paddr[11:0];
        hit = 1'b0;
        sel_port = 1'b0;
        if (paddr[31:12] == `GPIO_A_PAGE)
        begin
            hit = offset_known(off);
        end
        else if (paddr[31:12] == `GPIO_B_PAGE)
        begin
            hit = offset_known(off);
            sel_port = 1'b1;
        end
        setup = psel & ~penable;
        wr_go = psel & penable & state.pready & pwrite & hit;
        next_state.pready = setup;
        next_state.pslverr = setup & ~hit;
        next_state.prdata = '0;
        if (setup && hit && !pwrite)
        begin
            next_state.prdata = read_reg(state.port[sel_port], off);
        end
        for (int i = 0; i < 2; i++)
        begin
            if (port_soft_reset[i])
            begin
                next_state.port[i] = port_rst(i[0]);
            end
            else
            begin
                if (wr_go && sel_port == i[0])
                begin
                    next_state.port[i] = write_reg(state.port[i], off, pwdata, pin_mask(i[0]));
                end
                next_state.port[i].din = pad_in[i] & state.port[i].inen & pin_mask(i[0]);
                next_state.port[i] = pads(next_state.port[i]);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= RST_STATE;
        end
        else
        begin
            state <= next_state;
        end
    end

    always_comb
    begin
        prdata = state.prdata;
        pready = state.pready;
        pslverr = state.pslverr;
        for (int i = 0; i < 2; i++)
        begin
            pad_output_enable_n[i] = state.port[i].oe_n;
            pad_input_enable_n[i] = state.port[i].ie_n;
            pad_data_out[i] = state.port[i].dout;
            pad_opendrain[i] = state.port[i].od;
            pad_pullup[i] = state.port[i].pull_up;
            pad_pulldown[i] = state.port[i].pull_dn;
            pad_drive[i] = state.port[i].drv;
            altfunc_lock[i] = state.port[i].lock;
        end
    end

    for (genvar g = 0; g < 2; g++)
    begin : g_check
        a_pulldown_blocked: assert property (@(posedge pclk) disable iff (!presetn)
            (pad_pullup[g] & pad_pulldown[g]) == 16'h0000)
            else $error("pull-down active together with pull-up");

        a_input_gated: assert property (@(posedge pclk) disable iff (!presetn)
            $past(port_soft_reset[g]) == 1'b0 && $past(presetn)
            |-> state.port[g].din == ($past(pad_in[g]) & $past(state.port[g].inen)
                & pin_mask(g[0])))
            else $error("input bit not gated by input enable");

        a_lock_holds: assert property (@(posedge pclk) disable iff (!presetn)
            state.port[g].locked && !port_soft_reset[g] |=> state.port[g].locked)
            else $error("lock dropped without reset");

        a_locked_dir_frozen: assert property (@(posedge pclk) disable iff (!presetn)
            state.port[g].locked && !port_soft_reset[g]
            |=> ((state.port[g].dir ^ $past(state.port[g].dir)) & state.port[g].lock) == 16'h0
                && ((state.port[g].pu ^ $past(state.port[g].pu)) & state.port[g].lock) == 16'h0)
            else $error("locked pin configuration changed");

        a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
            ((state.port[g].dir | state.port[g].dout | state.port[g].inen)
                & ~pin_mask(g[0])) == 16'h0000)
            else $error("reserved pin bit set");

        a_oe_follows_dir: assert property (@(posedge pclk) disable iff (!presetn)
            pad_output_enable_n[g] == ~state.port[g].dir
                && pad_input_enable_n[g] == ~state.port[g].inen)
            else $error("pad enables do not follow direction and input enable");

        a_pulldown_masked: assert property (@(posedge pclk) disable iff (!presetn)
            pad_pulldown[g] == (state.port[g].pd & ~state.port[g].pu)
                && pad_pullup[g] == state.port[g].pu)
            else $error("pad pulls do not follow pull registers");

        a_drive_follows: assert property (@(posedge pclk) disable iff (!presetn)
            pad_drive[g] == state.port[g].drv)
            else $error("pad drive does not follow drive register");

        a_opendrain_follows: assert property (@(posedge pclk) disable iff (!presetn)
            pad_opendrain[g] == state.port[g].od)
            else $error("open-drain select does not reach the pad");

        a_dout_follows: assert property (@(posedge pclk) disable iff (!presetn)
            pad_data_out[g] == state.port[g].dout)
            else $error("pad data does not follow the output latch");

        a_lock_exported: assert property (@(posedge pclk) disable iff (!presetn)
            altfunc_lock[g] == state.port[g].lock)
            else $error("lock bits not passed to the function mux");

        a_soft_reset_clears: assert property (@(posedge pclk) disable iff (!presetn)
            port_soft_reset[g] |=> !state.port[g].locked && state.port[g].lock == 16'h0000)
            else $error("port reset did not release the lock");

        a_unlocked_no_bits: assert property (@(posedge pclk) disable iff (!presetn)
            !state.port[g].locked |-> state.port[g].lock == 16'h0000)
            else $error("lock bits held without a key");

        a_locked_pd_frozen: assert property (@(posedge pclk) disable iff (!presetn)
            state.port[g].locked && !port_soft_reset[g]
            |=> ((state.port[g].pd ^ $past(state.port[g].pd)) & state.port[g].lock) == 16'h0
                && ((state.port[g].od ^ $past(state.port[g].od)) & state.port[g].lock) == 16'h0)
            else $error("locked pull-down or open-drain changed");

        a_locked_inen_frozen: assert property (@(posedge pclk) disable iff (!presetn)
            state.port[g].locked && !port_soft_reset[g]
            |=> ((state.port[g].inen ^ $past(state.port[g].inen)) & state.port[g].lock) == 16'h0)
            else $error("locked input enable changed");

        a_locked_drv_frozen: assert property (@(posedge pclk) disable iff (!presetn)
            state.port[g].locked && !port_soft_reset[g]
            |=> ((state.port[g].drv ^ $past(state.port[g].drv)) & widen2(state.port[g].lock))
                == 32'h0)
            else $error("locked drive field changed");

        a_reserved_cfg_zero: assert property (@(posedge pclk) disable iff (!presetn)
            ((state.port[g].pu | state.port[g].pd | state.port[g].od) & ~pin_mask(g[0]))
                == 16'h0000)
            else $error("reserved configuration bit set");
    end

    // Clear-only writes must leave every written pin low
    a_clear_only: assert property (@(posedge pclk) disable iff (!presetn)
        wr_go && off == `GPIO_OFF_RR && !port_soft_reset[sel_port]
        |=> (pad_data_out[$past(sel_port)] & $past(pwdata[15:0])) == 16'h0000)
        else $error("clear-only write left a pin high");

    a_error_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !hit |=> pready && pslverr)
        else $error("unmapped access not flagged");

    a_quiet_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !psel |=> !pready && prdata == 32'h0000_0000)
        else $error("bus answer without a request");

    a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        wr_go && off == `GPIO_OFF_SRR && !port_soft_reset[sel_port]
        |=> (pad_data_out[$past(sel_port)] & $past(pwdata[15:0]))
            == ($past(pwdata[15:0]) & pin_mask($past(sel_port))))
        else $error("set request lost to clear");

    a_bad_key_dropped: assert property (@(posedge pclk) disable iff (!presetn)
        wr_go && off == `GPIO_OFF_LOCK && !state.port[sel_port].locked
            && pwdata[31:16] != `GPIO_LOCK_KEY
        |=> !state.port[$past(sel_port)].locked)
        else $error("lock taken with wrong key");

    a_wo_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && (off == `GPIO_OFF_SRR || off == `GPIO_OFF_RR)
        |=> pready && prdata == 32'h0000_0000)
        else $error("write-only register read non-zero");

    a_answer_timing: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready)
        else $error("bus answer not in first access cycle");

endmodule

/* core/gpio_params.svh */
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// Port pages on the bus: bits [31:12] of the byte address
`define GPIO_A_PAGE 20'h400b0
`define GPIO_B_PAGE 20'h400b2

// Register offsets inside a port page
`define GPIO_OFF_DIR 12'h000
`define GPIO_OFF_INEN 12'h004
`define GPIO_OFF_PU 12'h008
`define GPIO_OFF_PD 12'h00c
`define GPIO_OFF_OD 12'h010
`define GPIO_OFF_DRV 12'h014
`define GPIO_OFF_LOCK 12'h018
`define GPIO_OFF_DIN 12'h01c
`define GPIO_OFF_DOUT 12'h020
`define GPIO_OFF_SRR 12'h024
`define GPIO_OFF_RR 12'h028

// Implemented pins per port
`define GPIO_A_PIN_MASK 16'hf2ff
`define GPIO_B_PIN_MASK 16'h719f

// Lock register layout
`define GPIO_LOCK_KEY 16'h5fa0
`define GPIO_KEY_MSB 31
`define GPIO_KEY_LSB 16

// Reset values
`define GPIO_A_INEN_RST 16'h0200
`define GPIO_A_PU_RST 16'h3200
`define GPIO_A_DIN_RST 16'h3200
`define GPIO_B_CFG_RST 16'h0000

`endif

/* core/gpio_pkg.sv */
package gpio_pkg;

    typedef struct packed {
        logic [15:0] dir;
        logic [15:0] inen;
        logic [15:0] pu;
        logic [15:0] pd;
        logic [15:0] od;
        logic [31:0] drv;
        logic [15:0] lock;
        logic locked;
        logic [15:0] din;
        logic [15:0] dout;
        logic [15:0] oe_n;
        logic [15:0] ie_n;
        logic [15:0] pull_up;
        logic [15:0] pull_dn;
    } port_t;

    typedef struct packed {
        port_t [1:0] port;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;

endpackage

/* dv/pad_model.sv */
`timescale 1ns/10ps
module pad_model
(
    input wire logic pclk,
    input wire logic [1:0][15:0] oe_n,
    input wire logic [1:0][15:0] data_out,
    input wire logic [1:0][15:0] opendrain,
    input wire logic [1:0][15:0] pull_up,
    input wire logic [1:0][15:0] pull_down,
    input wire logic [1:0][15:0] ext_drive,
    input wire logic [1:0][15:0] ext_level,
    output logic [1:0][15:0] pad_level
);
    logic toggle = 1'b0;
    always @(posedge pclk)
        toggle <= ~toggle;
    // A floating pin shows a changing pattern so that no stale level can pass
    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            for (int n = 0; n < 16; n++)
            begin
                if (!oe_n[p][n] && !(opendrain[p][n] && data_out[p][n]))
                    pad_level[p][n] = data_out[p][n];
                else if (ext_drive[p][n])
                    pad_level[p][n] = ext_level[p][n];
                else if (pull_up[p][n] || pull_down[p][n])
                    pad_level[p][n] = pull_up[p][n];
                else
                    pad_level[p][n] = toggle ^ n[0];
            end
        end
    end
endmodule

/* dv/two_port_gpio_with_lock_bench.sv */
`timescale 1ns/10ps
module two_port_gpio_with_lock_bench;
    localparam logic [31:0] PA = 32'h400b_0000;
    localparam logic [31:0] PB = 32'h400b_2000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] port_soft_reset = 2'h0;
    logic [1:0][15:0] pad_in, oe_n, ie_n, dout, od, pu, pd, alock;
    logic [1:0][31:0] drv;
    logic [1:0][15:0] ext_drive = '0;
    logic [1:0][15:0] ext_level = '0;
    int bad_count = 0;
    int num_checks = 0;

    always #4 pclk = ~pclk;

    gpio_ports u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_soft_reset(port_soft_reset), .pad_in(pad_in),
        .pad_output_enable_n(oe_n), .pad_input_enable_n(ie_n), .pad_data_out(dout),
        .pad_opendrain(od), .pad_pullup(pu), .pad_pulldown(pd), .pad_drive(drv),
        .altfunc_lock(alock));

    pad_model u_pads (.pclk(pclk), .oe_n(oe_n), .data_out(dout), .opendrain(od),
        .pull_up(pu), .pull_down(pd), .ext_drive(ext_drive), .ext_level(ext_level),
        .pad_level(pad_in));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            bad_count++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        logic err;
        apb(1'b1, addr, wd, rd, err);
    endtask

    task automatic rd_chk(input string name, input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, addr, 32'h0, rd, err);
        chk(name, exp, rd);
        chk({name, "_err"}, 32'h0, {31'h0, err});
    endtask

    task automatic test_reset();
        chk("oe_n", 32'hffffffff, {oe_n[1], oe_n[0]});
        chk("ie_n", 32'hfffffdff, {ie_n[1], ie_n[0]});
        chk("pullup", 32'h00003200, {pu[1], pu[0]});
        chk("pulldown_lock", 32'h0, {pd[1], alock[0]});
        rd_chk("a_inen", PA + 32'h004, 32'h00000200);
        rd_chk("a_pu", PA + 32'h008, 32'h00003200);
        rd_chk("a_din", PA + 32'h01c, 32'h00000200);
        for (int i = 0; i < 7; i++)
            rd_chk("b_cfg", PB + 4 * i, 32'h0);
        $display("test reset done");
    endtask

    task automatic test_map();
        logic [31:0] rd;
        logic err;
        wr(PA, 32'hffffffff);
        rd_chk("a_dir", PA, 32'h0000f2ff);
        wr(PA, 32'h0);
        wr(PA + 32'h024, 32'hffff0000);
        rd_chk("a_srr", PA + 32'h024, 32'h0);
        rd_chk("a_rr", PA + 32'h028, 32'h0);
        apb(1'b0, PA + 32'h02c, 32'h0, rd, err);
        chk("unmapped", 32'h1, {31'h0, err});
        $display("test map done");
    endtask

    task automatic test_output();
        wr(PA, 32'h0000000f);
        wr(PA + 32'h020, 32'h00000005);
        @(posedge pclk);
        chk("pad_out", 32'hfff00005, {oe_n[0], dout[0]});
        wr(PA + 32'h024, 32'h00030002);
        rd_chk("dout_sr", PA + 32'h020, 32'h00000006);
        wr(PA + 32'h028, 32'h00000004);
        rd_chk("dout_r", PA + 32'h020, 32'h00000002);
        wr(PA + 32'h010, 32'h00000002);
        wr(PA + 32'h008, 32'h00000002);
        wr(PA + 32'h00c, 32'h00000003);
        wr(PA + 32'h004, 32'h0000000f);
        wr(PA + 32'h014, 32'h000000e4);
        @(posedge pclk);
        chk("od_pd", 32'h00020001, {od[0], pd[0]});
        chk("drive", 32'h000000e4, drv[0]);
        rd_chk("a_din", PA + 32'h01c, 32'h00000002);
        $display("test output done");
    endtask

    task automatic test_input();
        ext_drive[1] <= 16'h0003;
        ext_level[1] <= 16'h0003;
        wr(PB + 32'h004, 32'h00000001);
        repeat (2) @(posedge pclk);
        chk("b_ie_n", 32'h0000fffe, {16'h0, ie_n[1]});
        rd_chk("b_din", PB + 32'h01c, 32'h00000001);
        $display("test input done");
    endtask

    task automatic test_lock();
        wr(PA + 32'h018, 32'h12340001);
        rd_chk("lock_bad", PA + 32'h018, 32'h0);
        wr(PA + 32'h018, 32'h5fa00001);
        rd_chk("lock", PA + 32'h018, 32'h5fa00001);
        wr(PA, 32'h00000000);
        rd_chk("dir_lock", PA, 32'h00000001);
        wr(PA + 32'h018, 32'h5fa000ff);
        rd_chk("lock_again", PA + 32'h018, 32'h5fa00001);
        chk("af_lock", 32'h00000001, {16'h0, alock[0]});
        @(posedge pclk);
        port_soft_reset <= 2'b01;
        @(posedge pclk);
        port_soft_reset <= 2'b00;
        rd_chk("lock_rst", PA + 32'h018, 32'h0);
        rd_chk("b_inen", PB + 32'h004, 32'h00000001);
        $display("test lock done");
    endtask

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        test_reset();
        test_map();
        test_output();
        test_input();
        test_lock();
        tally_and_finish();
    end
endmodule
